// File: rtl/asi_rx_pkg.sv
// constants shared by the audio receive channel-map design
package aud_rx_pkg;

    // ********************************************************
    // register map (index; byte address is four times the index)
    // ********************************************************
    localparam int unsigned   ADDR_W       = 8;
    localparam int unsigned   IDX_PIN_SEL  = 32'h27;
    localparam int unsigned   IDX_CH1_CFG  = 32'h28;
    localparam int unsigned   IDX_CH2_CFG  = 32'h29;
    localparam int unsigned   IDX_FMT_CFG  = 32'h30;
    localparam int unsigned   IDX_STATUS   = 32'h31;
    localparam logic [7:0]    ADDR_PIN_SEL = 8'(IDX_PIN_SEL * 4);
    localparam logic [7:0]    ADDR_CH1_CFG = 8'(IDX_CH1_CFG * 4);
    localparam logic [7:0]    ADDR_CH2_CFG = 8'(IDX_CH2_CFG * 4);
    localparam logic [7:0]    ADDR_FMT_CFG = 8'(IDX_FMT_CFG * 4);
    localparam logic [7:0]    ADDR_STATUS  = 8'(IDX_STATUS * 4);

    // ********************************************************
    // reset values and field positions
    // ********************************************************
    localparam logic [7:0]    PIN_SEL_RST  = 8'h00;
    localparam logic [7:0]    CH1_CFG_RST  = 8'h20;
    localparam logic [7:0]    CH2_CFG_RST  = 8'h21;
    localparam logic [7:0]    FMT_CFG_RST  = 8'h00;
    localparam int unsigned   CFG_W        = 6;   // bits 7:6 reserved
    localparam int unsigned   EN_BIT       = 5;
    localparam int unsigned   SLOT_W       = 5;
    localparam int unsigned   FMT_LSB      = 0;
    localparam int unsigned   WLEN_LSB     = 2;
    localparam int unsigned   ST_OVERRUN   = 0;
    localparam int unsigned   ST_FRAMED    = 1;
    localparam int unsigned   ST_PENDING   = 2;
    localparam logic [5:0]    HALF_SLOTS   = 6'h10;
    localparam logic [5:0]    TDM_SLOTS    = 6'h20;

    // serial formats
    localparam logic [1:0]    FMT_TDM      = 2'h0;
    localparam logic [1:0]    FMT_I2S      = 2'h1;
    localparam logic [1:0]    FMT_LJ       = 2'h2;

    // axi4-lite responses
    localparam logic [1:0]    RESP_OKAY    = 2'h0;
    localparam logic [1:0]    RESP_SLVERR  = 2'h2;

    // word length code to bits per slot
    function automatic logic [5:0] wlen_bits(input logic [1:0] code);
        case (code)
            2'h0:    wlen_bits = 6'h10;
            2'h1:    wlen_bits = 6'h14;
            2'h2:    wlen_bits = 6'h18;
            default: wlen_bits = 6'h20;
        endcase
    endfunction : wlen_bits

endpackage : aud_rx_pkg

// File: rtl/pin_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk_i,    // system clock
    input  wire logic             rst_n_i,  // async reset, active low
    input  wire logic [WIDTH-1:0] async_i,  // raw pin levels
    output logic      [WIDTH-1:0] sync_o    // synchronised levels
);

    logic [WIDTH-1:0] meta_r;

    // ********************************************************
    // only the second stage is visible to logic
    // ********************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : pin_sync

// File: rtl/sample_fifo.sv
// synchronous fifo carrying received samples to the converter side
`timescale 1ns/1ps
module sample_fifo #(
    parameter int unsigned WIDTH = 33,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,        // system clock
    input  wire logic             rst_n_i,      // async reset, active low
    input  wire logic             in_valid_i,   // write request
    output logic                  in_ready_o,   // not full
    input  wire logic [WIDTH-1:0] in_data_i,    // write data
    output logic                  out_valid_o,  // not empty
    input  wire logic             out_ready_i,  // read accept
    output logic      [WIDTH-1:0] out_data_o    // head word
);

    localparam int unsigned AW = $clog2(DEPTH);

    // ********************************************************
    // parameter check
    // ********************************************************
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("sample_fifo depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;

    // full and empty from pointers with a wrap bit
    assign in_ready_o  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr_r != rd_ptr_r;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

    // storage has no reset; pointers define what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    // pointers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule : sample_fifo

// File: rtl/audio_rx_slot_channel_map.sv
// receive slot and pin mapping of the primary audio serial port
`timescale 1ns/1ps

module audio_rx_slot_channel_map
    import aud_rx_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 16
) (
    input  wire logic                          clk_i,          // 200 MHz
    input  wire logic                          rst_n_i,        // async, low
    // axi4-lite slave
    input  wire logic [aud_rx_pkg::ADDR_W-1:0] s_axi_awaddr,   // wr addr
    input  wire logic                          s_axi_awvalid,  // wr addr vld
    output logic                               s_axi_awready,  // wr addr rdy
    input  wire logic [31:0]                   s_axi_wdata,    // wr data
    input  wire logic [3:0]                    s_axi_wstrb,    // byte enables
    input  wire logic                          s_axi_wvalid,   // wr data vld
    output logic                               s_axi_wready,   // wr data rdy
    output logic [1:0]                         s_axi_bresp,    // wr response
    output logic                               s_axi_bvalid,   // wr resp vld
    input  wire logic                          s_axi_bready,   // wr resp rdy
    input  wire logic [aud_rx_pkg::ADDR_W-1:0] s_axi_araddr,   // rd addr
    input  wire logic                          s_axi_arvalid,  // rd addr vld
    output logic                               s_axi_arready,  // rd addr rdy
    output logic [31:0]                        s_axi_rdata,    // rd data
    output logic [1:0]                         s_axi_rresp,    // rd response
    output logic                               s_axi_rvalid,   // rd data vld
    input  wire logic                          s_axi_rready,   // rd data rdy
    // serial pins from the host processor
    input  wire logic                          bit_clk_i,      // bit clock
    input  wire logic                          frame_sync_i,   // frame sync
    input  wire logic                          primary_serial_data_in_i,
    input  wire logic                          secondary_serial_data_in_i,
    // converter-side sample stream
    output logic [31:0]                        sample_data_o,  // msb aligned
    output logic                               sample_chan_o,  // 0=ch1 1=ch2
    output logic                               sample_valid_o, // word ready
    input  wire logic                          sample_ready_i, // converter rdy
    output logic [7:0]                         rx_pin_select_o // ch8..ch1
);

    // ********************************************************
    // declarations
    // ********************************************************
    typedef enum logic [1:0] {EM_IDLE, EM_CH1, EM_CH2} emit_e;

    logic [7:0]       pin_sel_r, awaddr_r;
    logic [CFG_W-1:0] ch_cfg_r [2];
    logic [3:0]       fmt_cfg_r, pins_s;
    logic             overrun_r, aw_held_r, w_held_r, wstrb0_r, do_write;
    logic [31:0]      wdata_r;
    logic             bclk_d_r, bclk_rise, fs_s, fs_prev_r;
    logic             pend_r, pend_half_r, framed_r, start_now, start_half;
    logic [5:0]       wl, bit_r, sih_r, cur_bit, cur_sih;
    logic             half_r, cur_half, slot_ok, frame_start;
    logic [4:0]       cur_slot;
    logic [31:0]      sh_r   [2];
    logic [31:0]      hold_r [2];
    logic             got_r  [2];
    logic [31:0]      out_r  [2];
    emit_e            emit_r;
    logic             fifo_in_valid, fifo_in_ready;
    logic [32:0]      fifo_in_data, fifo_out_data;

    // byte address with the two low bits ignored
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction : word_addr

    function automatic logic addr_hit(input logic [7:0] a);
        case (word_addr(a))
            ADDR_PIN_SEL, ADDR_CH1_CFG, ADDR_CH2_CFG,
            ADDR_FMT_CFG, ADDR_STATUS: addr_hit = 1'b1;
            default:                   addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // ********************************************************
    // axi4-lite write path
    // ********************************************************
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;

    // address and data taken in either order, then one response
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= '0;
            wdata_r      <= '0;
            wstrb0_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; only byte lane 0 carries data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sel_r  <= PIN_SEL_RST;
            ch_cfg_r[0] <= CH1_CFG_RST[CFG_W-1:0];
            ch_cfg_r[1] <= CH2_CFG_RST[CFG_W-1:0];
            fmt_cfg_r  <= FMT_CFG_RST[3:0];
        end else if (do_write && wstrb0_r) begin
            case (word_addr(awaddr_r))
                ADDR_PIN_SEL: pin_sel_r   <= wdata_r[7:0];
                // reserved bits are not stored and read back as zero
                ADDR_CH1_CFG: ch_cfg_r[0] <= wdata_r[CFG_W-1:0];
                ADDR_CH2_CFG: ch_cfg_r[1] <= wdata_r[CFG_W-1:0];
                ADDR_FMT_CFG: fmt_cfg_r   <= wdata_r[3:0];
                default:      ;
            endcase
        end
    end

    assign rx_pin_select_o = pin_sel_r;

    // ********************************************************
    // axi4-lite read path
    // ********************************************************
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (word_addr(s_axi_araddr))
                ADDR_PIN_SEL: s_axi_rdata <= {24'h0, pin_sel_r};
                ADDR_CH1_CFG: s_axi_rdata <= {26'h0, ch_cfg_r[0]};
                ADDR_CH2_CFG: s_axi_rdata <= {26'h0, ch_cfg_r[1]};
                ADDR_FMT_CFG: s_axi_rdata <= {28'h0, fmt_cfg_r};
                ADDR_STATUS:  s_axi_rdata <= {29'h0, sample_valid_o,
                                              framed_r, overrun_r};
                default:      s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ********************************************************
    // pin sampling and bit clock edge detection
    // ********************************************************
    pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({bit_clk_i, frame_sync_i, primary_serial_data_in_i,
                   secondary_serial_data_in_i}),
        .sync_o  (pins_s)
    );

    // all pins share one sync latency so data stays aligned to the edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bclk_d_r <= 1'b0;
        end else begin
            bclk_d_r <= pins_s[3];
        end
    end

    assign bclk_rise = pins_s[3] & ~bclk_d_r;
    assign fs_s      = pins_s[2];
    assign wl        = wlen_bits(fmt_cfg_r[WLEN_LSB +: 2]);

    // ********************************************************
    // frame boundary: tdm on sync rise, lj on either edge,
    // i2s one bit clock after either edge (low half is left)
    // ********************************************************
    always_comb begin
        if (fmt_cfg_r[FMT_LSB +: 2] == FMT_I2S) begin
            start_now  = pend_r;
            start_half = pend_half_r;
        end else if (fmt_cfg_r[FMT_LSB +: 2] == FMT_LJ) begin
            start_now  = fs_s ^ fs_prev_r;
            start_half = ~fs_s;
        end else begin
            start_now  = fs_s & ~fs_prev_r;
            start_half = 1'b0;
        end
    end

    assign cur_bit     = start_now ? 6'h0 : bit_r;
    assign cur_sih     = start_now ? 6'h0 : sih_r;
    assign cur_half    = start_now ? start_half : half_r;
    assign frame_start = bclk_rise & start_now & ~start_half;

    // tdm reaches slot 31, each i2s/lj half holds 16 slots
    always_comb begin
        if (fmt_cfg_r[FMT_LSB +: 2] == FMT_TDM) begin
            slot_ok  = framed_r & (cur_sih < TDM_SLOTS);
            cur_slot = cur_sih[4:0];
        end else begin
            slot_ok  = framed_r & (cur_sih < HALF_SLOTS);
            cur_slot = {cur_half, cur_sih[3:0]};
        end
    end

    // bit counter advances once per bit clock, slot counter once per word
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_prev_r   <= 1'b0;
            pend_r      <= 1'b0;
            pend_half_r <= 1'b0;
            framed_r    <= 1'b0;
            bit_r       <= '0;
            sih_r       <= '0;
            half_r      <= 1'b0;
        end else if (bclk_rise) begin
            fs_prev_r   <= fs_s;
            pend_r      <= fs_s ^ fs_prev_r;
            pend_half_r <= fs_s;
            half_r      <= cur_half;
            if (start_now) begin
                framed_r <= 1'b1;
            end
            if (cur_bit == wl - 6'h1) begin
                bit_r <= '0;
                // saturate so trailing bits never alias a low slot
                sih_r <= (cur_sih == 6'h3f) ? cur_sih : cur_sih + 6'h1;
            end else begin
                bit_r <= cur_bit + 6'h1;
                sih_r <= cur_sih;
            end
        end
    end

    // ********************************************************
    // per-channel capture for converter channels 1 and 2
    // ********************************************************
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic match;
        logic din;

        // pin choice from the channel's select bit
        assign din   = pin_sel_r[c] ? pins_s[0] : pins_s[1];
        assign match = slot_ok & (cur_slot == ch_cfg_r[c][SLOT_W-1:0]);

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                sh_r[c]   <= '0;
                hold_r[c] <= '0;
                got_r[c]  <= 1'b0;
            end else if (bclk_rise) begin
                // an ignored channel never shifts
                if (match && ch_cfg_r[c][EN_BIT]) begin
                    if (cur_bit == 6'h0) begin
                        sh_r[c]     <= '0;
                        sh_r[c][31] <= din;
                    end else begin
                        sh_r[c][5'(6'd31 - cur_bit)] <= din;
                    end
                    if (cur_bit == wl - 6'h1) begin
                        hold_r[c]                  <= sh_r[c];
                        hold_r[c][5'(6'd31 - cur_bit)] <= din;
                        got_r[c]                   <= 1'b1;
                    end
                end
                if (frame_start) begin
                    got_r[c] <= 1'b0;
                end
            end
        end
    end

    // ********************************************************
    // per-frame emit into the fifo; a busy emitter drops the
    // new frame and flags overrun rather than mixing frames
    // ********************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            emit_r   <= EM_IDLE;
            out_r[0] <= '0;
            out_r[1] <= '0;
        end else begin
            case (emit_r)
                EM_IDLE: begin
                    if (frame_start && framed_r) begin
                        for (int c = 0; c < 2; c++) begin
                            // disabled or missing channel sends zero
                            out_r[c] <= (ch_cfg_r[c][EN_BIT] && got_r[c])
                                        ? hold_r[c] : 32'h0;
                        end
                        emit_r <= EM_CH1;
                    end
                end
                EM_CH1: begin
                    if (fifo_in_ready) begin
                        emit_r <= EM_CH2;
                    end
                end
                EM_CH2: begin
                    if (fifo_in_ready) begin
                        emit_r <= EM_IDLE;
                    end
                end
                default: emit_r <= EM_IDLE;
            endcase
        end
    end

    // overrun is sticky; write 1 clears, a new event wins the tie
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overrun_r <= 1'b0;
        end else if (frame_start && framed_r && emit_r != EM_IDLE) begin
            overrun_r <= 1'b1;
        end else if (do_write && wstrb0_r && wdata_r[ST_OVERRUN]
                     && word_addr(awaddr_r) == ADDR_STATUS) begin
            overrun_r <= 1'b0;
        end
    end

    assign fifo_in_valid = emit_r != EM_IDLE;
    assign fifo_in_data  = (emit_r == EM_CH2) ? {1'b1, out_r[1]}
                                              : {1'b0, out_r[0]};

    sample_fifo #(
        .WIDTH (33),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (sample_valid_o),
        .out_ready_i (sample_ready_i),
        .out_data_o  (fifo_out_data)
    );

    assign sample_data_o = fifo_out_data[31:0];
    assign sample_chan_o = fifo_out_data[32];

endmodule : audio_rx_slot_channel_map

// File: tb/audio_rx_slot_channel_map_assertions.sv
// port-level assertions for the receive channel map
`timescale 1ns/1ps
module audio_rx_slot_channel_map_assertions (
    input wire logic        clk_i, rst_n_i, s_axi_awready, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready, sample_valid_o,
    input wire logic        sample_ready_i,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata, sample_data_o,
    input wire logic [7:0]  rx_pin_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ********************************************************
    // register and handshake relations
    // ********************************************************
    chk_sel_reset: assert property (
        $rose(rst_n_i) |-> rx_pin_select_o == 8'h00) else $error("sel");
    chk_sel_write: assert property (
        !$stable(rx_pin_select_o) |-> $rose(s_axi_bvalid)) else $error("wr");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
    chk_out_hold: assert property (sample_valid_o && !sample_ready_i
        |=> sample_valid_o && $stable(sample_data_o)) else $error("out");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready");
    chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready");
    chk_w_busy: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("wready");
endmodule : audio_rx_slot_channel_map_assertions
bind audio_rx_slot_channel_map
    audio_rx_slot_channel_map_assertions chk_i (.*);

// File: tb/host_serial_model.sv
// host source sending frames of four 16-bit slots
`timescale 1ns/1ps
module host_serial_model (
    output logic bit_clk_o,    // stands low between frames
    output logic frame_sync_o, // high for the first fs_len bits
    output logic pri_o,        // primary data pin
    output logic sec_o         // secondary data pin
);
    int fs_len = 1; // 1 for tdm, 32 for a left-justified left half
    initial {bit_clk_o, frame_sync_o, pri_o, sec_o} = 4'h0;
    // msb first, lines change while the clock is low
    task frame(input logic [63:0] p, s);
        for (int i = 63; i >= 0; i--) begin
            {frame_sync_o, pri_o, sec_o} = {i > 63 - fs_len, p[i], s[i]};
            #24 bit_clk_o = 1;
            #24 bit_clk_o = 0;
        end
        // flip released lines so no stale level passes for data
        {pri_o, sec_o} = ~{pri_o, sec_o};
    endtask : frame
endmodule : host_serial_model

// File: tb/audio_rx_slot_channel_map_bench.sv
// bench for the receive channel map with a queue reference model
`timescale 1ns/1ps
module audio_rx_slot_channel_map_bench;
    import aud_rx_pkg::*;
    logic clk_i = 0, rst_n_i = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic rdy = 0, lj = 0, bclk, fs, d0, d1, awr, wrd, bv, arr, rv;
    logic chan, sv;
    logic [1:0] bresp, rresp;
    logic [7:0] awa = 0, ara = 0, psel, sel_m = 8'h00, c1_m = 8'h20;
    logic [7:0] c2_m = 8'h21;
    logic [31:0] wd = 0, rdat, sd;
    logic [32:0] q[$];
    int error_cnt = 0, tests_run = 0, cyc = 0;
    audio_rx_slot_channel_map audio_rx_slot_channel_map_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .bit_clk_i(bclk), .frame_sync_i(fs),
        .primary_serial_data_in_i(d0), .secondary_serial_data_in_i(d1),
        .sample_data_o(sd), .sample_chan_o(chan), .sample_valid_o(sv),
        .sample_ready_i(rdy), .rx_pin_select_o(psel));
    host_serial_model host_serial_model_i (.bit_clk_o(bclk),
        .frame_sync_o(fs), .pri_o(d0), .sec_o(d1));
    initial forever #2.5 clk_i = ~clk_i;
    task chk(input logic [32:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // bready rises only once bvalid is seen, so the stall path is used
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {awa, wd, awv, wv} <= {a, 24'h0, d, 2'b11};
        do begin
            @(posedge clk_i);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
            if (bv) br <= 1;
        end while (!(bv && br));
        br <= 0;
        chk(bresp, RESP_OKAY);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [32:0] e, input logic [1:0] r);
        @(posedge clk_i);
        {ara, arv} <= {a, 1'b1};
        do begin
            @(posedge clk_i);
            if (arr) arv <= 0;
            if (rv) rr <= 1;
        end while (!(rv && rr));
        rr <= 0;
        chk(rdat, e);
        chk(rresp, r);
    endtask : rdc
    function automatic logic [31:0] ex(input logic [63:0] p, s,
                                       input logic b, input logic [7:0] c);
        logic [63:0] v;
        v = b ? s : p;
        // left-justified values from 16 pick the half 32 bits in
        return c[5] ? {v[63 - 16 * (lj ? 2 * c[4] + c[3:0] : c[4:0]) -: 16],
                       16'h0} : 32'h0;
    endfunction : ex
    // a frame's pair is predicted with the config in force while it runs;
    // each frame comes out at the start of the next, so the last stays
    task fr(input logic [63:0] p, s);
        q.push_back({1'b0, ex(p, s, sel_m[0], c1_m)});
        q.push_back({1'b1, ex(p, s, sel_m[1], c2_m)});
        host_serial_model_i.frame(p, s);
    endtask : fr
    // converter side stalls at random; every popped word is compared
    always @(posedge clk_i) begin
        rdy <= 1'($urandom);
        if (sv && rdy)
            chk({chan, sd}, q.pop_front());
        if (++cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(33));
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1;
        rdc(ADDR_PIN_SEL, 8'h00, RESP_OKAY);
        rdc(ADDR_CH1_CFG, 8'h20, RESP_OKAY);
        rdc(ADDR_CH2_CFG, 8'h21, RESP_OKAY);
        rdc(8'h00, 0, RESP_SLVERR);
        fr(0, 0);
        for (int k = 0; k < 8; k++) begin
            // later rounds are left-justified, sync high for the left half
            if (k == 5) begin
                lj = 1;
                host_serial_model_i.fs_len = 32;
                wr(ADDR_FMT_CFG, 8'(FMT_LJ));
            end
            if (k > 0) begin
                sel_m = 8'($urandom);
                c1_m = 8'($urandom) & (lj ? 8'h31 : 8'h23);
                c2_m = 8'($urandom) & (lj ? 8'h31 : 8'h23);
                wr(ADDR_PIN_SEL, sel_m);
                wr(ADDR_CH1_CFG, c1_m);
                wr(ADDR_CH2_CFG, c2_m);
                rdc(ADDR_CH1_CFG, c1_m, RESP_OKAY);
                chk(psel, sel_m);
            end
            fr({$urandom, $urandom}, {$urandom, $urandom});
            fr(0, 0);
        end
        chk(33'(q.size()), 2);
        wrap_up();
    end
endmodule : audio_rx_slot_channel_map_bench
